// ==== shared/lss_regs.svh ====
`ifndef LSS_REGS_SVH
`define LSS_REGS_SVH

// Line addressing: 64 lines, 8 groups of 8 modules
`define LSS_LINES      64
`define LSS_LINE_W     6
`define LSS_GROUPS     8
`define LSS_GRP_LSB    3
`define LSS_ADDR_FIRST 6'h00
`define LSS_ADDR_LAST  6'h3f
`define LSS_ADDR_STEP  6'h01

// Line number field in the host data word, bits 26 to 31
`define LSS_WORD_LINE_MSB 31
`define LSS_WORD_LINE_LSB 26

// Character and buffering
`define LSS_CHAR_W     8
`define LSS_FIFO_DEPTH 4

// Cycles allowed for a halted line's character to pass its synchroniser
`define LSS_SETTLE_CYC 2'h2

// Direct instruction function codes
`define LSS_FN_OUT_RESP 4'h0
`define LSS_FN_XMIT     4'h9
`define LSS_FN_LSPACE   4'ha
`define LSS_FN_STOP     4'hb

// Host channel operations that compare the address switches
`define LSS_OP_START    3'h1
`define LSS_OP_TEST     3'h2
`define LSS_OP_TESTDEV  3'h3
`define LSS_OP_HALT     3'h4

`endif

// ==== shared/lss_pkg.sv ====
`include "lss_regs.svh"

package lss_pkg;

    typedef enum logic [1:0] {RX_SCAN, RX_SETTLE, RX_PUSH, RX_CLEAR} lss_rx_st_e;
    typedef enum logic {TX_SCAN, TX_HALT} lss_tx_st_e;

    typedef struct packed {
        logic [`LSS_LINES-1:0]  rx_rdy_m;
        logic [`LSS_LINES-1:0]  rx_rdy_s;
        logic [`LSS_LINES-1:0]  tx_done_m;
        logic [`LSS_LINES-1:0]  tx_done_s;
        logic [`LSS_CHAR_W-1:0] char_m;
        logic [`LSS_CHAR_W-1:0] char_s;
        logic [7:0]             sw_m;
        logic [7:0]             sw_s;
        logic [2:0]             pin_m;
        logic [2:0]             pin_s;
        logic [`LSS_LINE_W-1:0] rx_addr;
        logic [`LSS_LINE_W-1:0] tx_addr;
        lss_rx_st_e             rx_st;
        lss_tx_st_e             tx_st;
        logic [1:0]             settle;
        logic                   rx_take;
        logic                   send_irq;
        logic [`LSS_LINE_W-1:0] dio_rdata;
        logic                   dio_rvalid;
        logic [`LSS_GROUPS-1:0] fmt3_tick;
        logic                   io_selected;
    } lss_state_s;

endpackage

// ==== shared/lss_fifo_if.sv ====
`timescale 1ns/1ps

interface lss_fifo_if #(parameter int WIDTH = 14);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;

    modport fill  (output in_valid, output in_data, input in_ready,
                   input out_valid, input out_data, output out_ready);
    modport store (input in_valid, input in_data, output in_ready,
                   output out_valid, output out_data, input out_ready);
endinterface

// ==== logic/lss_fifo.sv ====
`timescale 1ns/1ps

module lss_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Buffer ports
    lss_fifo_if.store f
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               rd;
        logic [PW-1:0]               wr;
        logic [PW:0]                 count;
    } lss_fifo_s;

    lss_fifo_s st;
    lss_fifo_s next_st;
    logic      push;
    logic      pop;

    // Depth must be a power of two of at least two
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("lss_fifo: DEPTH must be a power of two >= 2");
    end

    // Handshakes
    assign f.in_ready  = (st.count != (PW+1)'(DEPTH));
    assign f.out_valid = (st.count != '0);
    assign f.out_data  = st.mem[st.rd];
    assign push        = f.in_valid && f.in_ready;
    assign pop         = f.out_valid && f.out_ready;

    // Pointer and storage update
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wr] = f.in_data;
            next_st.wr         = st.wr + 1'b1;
        end
        if (pop)
        begin
            next_st.rd = st.rd + 1'b1;
        end
        next_st.count = st.count + (PW+1)'(push) - (PW+1)'(pop);
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ==== logic/lss_scanner.sv ====
// Operation
// R1: Receive scanner counts 0 to 63, wraps
// R2: Separate send scanner counts 0 to 63
// R3: Six address bits: group and module
// R4: Scan group 0 first through group 7
// R5: Ready receiver halts scanner, requests service
// R6: Halted: deliver character with scanner line
// R7: Done sender halts scanner, raises interrupt
// R8: Output response read returns send line
// R9: Send scanner holds until write to line
// R10: Any direct instruction freezes send scanner; code instead jumps it to 63 on a far-group send service write with the option
// R11: Send module address broadcast to groups
// R12: High-speed timing only to group 0
// R13: Far-group send service forces address 63
// R14: Far-group receive delivery forces address 63
// R15: Send modules serialise independently per line
// R16: Receive modules share group format timing
// R17: Up to eight groups of eight lines
// R18: Address switches compared on channel ops
// R19: Line number rides data bits 26-31
// R20: Idle scanner advances one address per step
`timescale 1ns/1ps
`include "lss_regs.svh"

module lss_scanner #(
    parameter int GROUPS = `LSS_GROUPS,
    parameter int DEPTH  = `LSS_FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset_n,
    // Receive modules
    input  wire logic [`LSS_LINES-1:0]  rx_ready,
    input  wire logic [`LSS_CHAR_W-1:0] rx_char,
    output logic [`LSS_LINE_W-1:0]      rx_line,
    output logic [`LSS_GROUPS-1:0]      rx_grp_sel,
    output logic                        rx_take,
    // Send modules
    input  wire logic [`LSS_LINES-1:0]  tx_done,
    output logic [`LSS_LINE_W-1:0]      tx_line,
    output logic [2:0]                  tx_mod_addr,
    output logic [`LSS_GROUPS-1:0]      tx_grp_sel,
    // Format group timing
    input  wire logic                   hs_option,
    input  wire logic                   hs_tick,
    input  wire logic                   ls_tick,
    output logic [`LSS_GROUPS-1:0]      fmt3_tick,
    // Input processor
    output logic                        mip_valid,
    output logic [`LSS_CHAR_W-1:0]      mip_char,
    output logic [`LSS_LINE_W-1:0]      mip_line,
    input  wire logic                   mip_ready,
    // Direct host port
    input  wire logic                   dio_valid,
    input  wire logic                   dio_read,
    input  wire logic [3:0]             dio_func,
    input  wire logic [`LSS_LINE_W-1:0] dio_line,
    output logic [`LSS_LINE_W-1:0]      dio_rdata,
    output logic                        dio_rvalid,
    output logic                        send_irq,
    // Host channel selection
    input  wire logic [7:0]             addr_switch,
    input  wire logic [7:0]             dev_num,
    input  wire logic                   io_op_valid,
    input  wire logic [2:0]             io_op,
    output logic                        io_selected
);
    localparam int FW = `LSS_LINE_W + `LSS_CHAR_W;

    lss_pkg::lss_state_s st;
    lss_pkg::lss_state_s next_st;
    logic                hs_on;
    logic                dio_wr;
    logic                tx_svc;
    logic                op_match;

    lss_fifo_if #(.WIDTH(FW)) fq ();

    // Group count must fit the three group bits
    if (GROUPS < 1 || GROUPS > `LSS_GROUPS)
    begin : g_bad_groups
        $error("lss_scanner: GROUPS must be 1 to 8");
    end

    // Line lies in an installed group
    function automatic logic line_present(input logic [`LSS_LINE_W-1:0] a);
        return int'(a[`LSS_LINE_W-1:`LSS_GRP_LSB]) < GROUPS; // R17
    endfunction

    // One-hot group select from the upper three address bits
    function automatic logic [`LSS_GROUPS-1:0] grp_decode(input logic [`LSS_LINE_W-1:0] a);
        logic [`LSS_GROUPS-1:0] g;
        g = '0;
        g[a[`LSS_LINE_W-1:`LSS_GRP_LSB]] = 1'b1; // R3
        return g;
    endfunction

    // Next scan address: last line when forced, else one step with wrap
    function automatic logic [`LSS_LINE_W-1:0] step_addr(input logic [`LSS_LINE_W-1:0] a,
                                                          input logic                   force_last);
        logic [`LSS_LINE_W-1:0] n;
        n = a + `LSS_ADDR_STEP; // R1 R2 R4
        if (force_last)
        begin
            n = `LSS_ADDR_LAST;
        end
        return n;
    endfunction

    // Decodes of the synchronised option pin and same-clock host requests
    assign hs_on    = st.pin_s[0];
    assign dio_wr   = dio_valid && !dio_read;
    assign tx_svc   = (dio_func == `LSS_FN_XMIT) || (dio_func == `LSS_FN_STOP)
                   || (dio_func == `LSS_FN_LSPACE);
    assign op_match = (io_op == `LSS_OP_START) || (io_op == `LSS_OP_TEST)
                   || (io_op == `LSS_OP_TESTDEV) || (io_op == `LSS_OP_HALT);

    // Character and scanner line enter the buffer while pushing
    assign fq.in_valid  = (st.rx_st == lss_pkg::RX_PUSH); // R5
    assign fq.in_data   = {st.rx_addr, st.char_s};        // R6
    assign fq.out_ready = mip_ready;

    // Input processor side of the buffer
    assign mip_valid = fq.out_valid;
    assign mip_line  = fq.out_data[FW-1:`LSS_CHAR_W];
    assign mip_char  = fq.out_data[`LSS_CHAR_W-1:0];

    // Module select lines follow the scanner flip-flops
    assign rx_line     = st.rx_addr;
    assign rx_grp_sel  = grp_decode(st.rx_addr);
    assign rx_take     = st.rx_take;
    assign tx_line     = st.tx_addr;
    assign tx_mod_addr = st.tx_addr[`LSS_GRP_LSB-1:0]; // R11
    assign tx_grp_sel  = grp_decode(st.tx_addr);       // R11

    // Registered host-facing and format timing outputs
    assign dio_rdata   = st.dio_rdata;
    assign dio_rvalid  = st.dio_rvalid;
    assign send_irq    = st.send_irq;
    assign fmt3_tick   = st.fmt3_tick;
    assign io_selected = st.io_selected;

    lss_fifo #(
        .WIDTH (FW),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk     (clk),
        .reset_n (reset_n),
        .f       (fq.store)
    );

    // Next-state logic for synchronisers, both scanners and host port
    always_comb
    begin
        next_st = st;

        // Pin inputs pass two flip-flops before use
        next_st.rx_rdy_m  = rx_ready;
        next_st.rx_rdy_s  = st.rx_rdy_m;
        next_st.tx_done_m = tx_done;       // R15
        next_st.tx_done_s = st.tx_done_m;
        next_st.char_m    = rx_char;
        next_st.char_s    = st.char_m;
        next_st.sw_m      = addr_switch;
        next_st.sw_s      = st.sw_m;
        next_st.pin_m     = {ls_tick, hs_tick, hs_option};
        next_st.pin_s     = st.pin_m;

        // Format III timing: fast ticks only to group 0 with the option
        for (int g = 0; g < `LSS_GROUPS; g++)
        begin
            next_st.fmt3_tick[g] = st.pin_s[2]; // R12 R16
        end
        if (hs_on)
        begin
            next_st.fmt3_tick[0] = st.pin_s[1]; // R12
        end

        // Receive scanner
        next_st.rx_take = 1'b0;
        case (st.rx_st)
            lss_pkg::RX_SCAN:
            begin
                if (st.rx_rdy_s[st.rx_addr] && line_present(st.rx_addr))
                begin
                    next_st.rx_st  = lss_pkg::RX_SETTLE; // R5
                    next_st.settle = `LSS_SETTLE_CYC;
                end
                else
                begin
                    next_st.rx_addr = step_addr(st.rx_addr, 1'b0); // R1 R20
                end
            end
            lss_pkg::RX_SETTLE:
            begin
                // Let the halted line's character through its synchroniser
                if (st.settle == 2'h0)
                begin
                    next_st.rx_st = lss_pkg::RX_PUSH;
                end
                else
                begin
                    next_st.settle = st.settle - 2'h1;
                end
            end
            lss_pkg::RX_PUSH:
            begin
                // Full buffer stalls the scanner here
                if (fq.in_ready)
                begin
                    next_st.rx_take = 1'b1; // R6
                    next_st.rx_st   = lss_pkg::RX_CLEAR;
                end
            end
            lss_pkg::RX_CLEAR:
            begin
                // Wait for the module to drop its request, then move on
                if (!st.rx_rdy_s[st.rx_addr])
                begin
                    next_st.rx_addr = step_addr(st.rx_addr,
                        hs_on && (st.rx_addr[`LSS_LINE_W-1:`LSS_GRP_LSB] != 3'h0)); // R14
                    next_st.rx_st   = lss_pkg::RX_SCAN;
                end
            end
            default:
            begin
                next_st.rx_st = lss_pkg::RX_SCAN;
            end
        endcase

        // Send scanner
        case (st.tx_st)
            lss_pkg::TX_SCAN:
            begin
                if (dio_valid)
                begin
                    // Shared address lines: hold still during a direct instruction unless a far-group send service with the option forces the last line
                    if (dio_wr && tx_svc && hs_on && (dio_line[`LSS_LINE_W-1:`LSS_GRP_LSB] != 3'h0))
                    begin
                        next_st.tx_addr = `LSS_ADDR_LAST; // R13
                    end
                end // R10
                else if (st.tx_done_s[st.tx_addr] && line_present(st.tx_addr))
                begin
                    next_st.tx_st    = lss_pkg::TX_HALT; // R7
                    next_st.send_irq = 1'b1;             // R7
                end
                else
                begin
                    next_st.tx_addr = step_addr(st.tx_addr, 1'b0); // R2 R20
                end
            end
            lss_pkg::TX_HALT:
            begin
                // Only a write to the halted line resumes scanning
                if (dio_wr && (dio_line == st.tx_addr))
                begin
                    next_st.send_irq = 1'b0; // R9
                    next_st.tx_st    = lss_pkg::TX_SCAN;
                    next_st.tx_addr  = step_addr(st.tx_addr,
                        tx_svc && hs_on && (st.tx_addr[`LSS_LINE_W-1:`LSS_GRP_LSB] != 3'h0)); // R13
                end
            end
            default:
            begin
                next_st.tx_st = lss_pkg::TX_SCAN;
            end
        endcase

        // Direct read: output response returns the send scanner line
        next_st.dio_rvalid = dio_valid && dio_read;
        if (dio_valid && dio_read)
        begin
            next_st.dio_rdata = (dio_func == `LSS_FN_OUT_RESP) ? st.tx_addr : '0; // R8 R19
        end

        // Channel selection against the address switches
        next_st.io_selected = io_op_valid ? (op_match && (st.sw_s == dev_num))
                                          : st.io_selected; // R18
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st         <= '0;
            st.rx_addr <= `LSS_ADDR_FIRST;
            st.tx_addr <= `LSS_ADDR_FIRST;
            st.rx_st   <= lss_pkg::RX_SCAN;
            st.tx_st   <= lss_pkg::TX_SCAN;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule

// ==== tb/lss_scanner_properties.sv ====
`timescale 1ns/1ps
`include "lss_regs.svh"

module lss_scanner_chk #(
    parameter int GROUPS = 8,
    parameter int DEPTH  = 4
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset_n,
    // Scanners
    input wire logic [5:0] rx_line,
    input wire logic [7:0] rx_grp_sel,
    input wire logic       rx_take,
    input wire logic [5:0] tx_line,
    input wire logic [2:0] tx_mod_addr,
    input wire logic [7:0] tx_grp_sel,
    input wire logic [7:0] fmt3_tick,
    // Input processor
    input wire logic       mip_valid,
    input wire logic       mip_ready,
    input wire logic [7:0] mip_char,
    input wire logic [5:0] mip_line,
    // Direct host port
    input wire logic       dio_valid,
    input wire logic       dio_read,
    input wire logic [3:0] dio_func,
    input wire logic [5:0] dio_line,
    input wire logic [5:0] dio_rdata,
    input wire logic       dio_rvalid,
    input wire logic       send_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Scanners only step by one or jump to the last line
    rx_step_a: assert property (
        $changed(rx_line) |-> rx_line == $past(rx_line) + 6'h01 || rx_line == 6'h3f)
        else $error("receive line jumped");
    tx_step_a: assert property (
        $changed(tx_line) |-> tx_line == $past(tx_line) + 6'h01 || tx_line == 6'h3f)
        else $error("send line jumped");
    addr_decode_a: assert property (
        rx_grp_sel == 8'h01 << rx_line[5:3] && tx_grp_sel == 8'h01 << tx_line[5:3]
        && tx_mod_addr == tx_line[2:0]) else $error("group decode wrong");
    // Halted send scanner waits for the write to its line
    irq_hold_a: assert property (
        send_irq && !(dio_valid && !dio_read && dio_line == tx_line) |=> send_irq && $stable(tx_line))
        else $error("send halt lost");
    irq_release_a: assert property (
        send_irq && dio_valid && !dio_read && dio_line == tx_line |=> !send_irq)
        else $error("send halt kept");
    read_freeze_a: assert property (
        dio_valid && dio_read |=> $stable(tx_line)) else $error("send scan moved on read");
    resp_line_a: assert property (
        dio_valid && dio_read && dio_func == `LSS_FN_OUT_RESP |=> dio_rvalid && dio_rdata == $past(tx_line))
        else $error("response line wrong");
    take_halt_a: assert property (
        rx_take |-> $past(rx_line, 2) == rx_line ##1 !rx_take) else $error("take while scanning");
    mip_hold_a: assert property (
        mip_valid && !mip_ready |=> mip_valid && $stable(mip_line) && $stable(mip_char))
        else $error("processor word dropped");
    fmt_far_a: assert property (
        fmt3_tick[7:1] == 7'h00 || fmt3_tick[7:1] == 7'h7f) else $error("far groups split");

    // Main scenarios
    cover property (rx_take);
    cover property (send_irq ##1 !send_irq);
    cover property (mip_valid && !mip_ready);
endmodule

bind lss_scanner lss_scanner_chk #(.GROUPS(GROUPS), .DEPTH(DEPTH)) u_chk (
    .clk(clk), .reset_n(reset_n), .rx_line(rx_line), .rx_grp_sel(rx_grp_sel), .rx_take(rx_take),
    .tx_line(tx_line), .tx_mod_addr(tx_mod_addr), .tx_grp_sel(tx_grp_sel), .fmt3_tick(fmt3_tick),
    .mip_valid(mip_valid), .mip_ready(mip_ready), .mip_char(mip_char), .mip_line(mip_line),
    .dio_valid(dio_valid), .dio_read(dio_read), .dio_func(dio_func), .dio_line(dio_line),
    .dio_rdata(dio_rdata), .dio_rvalid(dio_rvalid), .send_irq(send_irq)
);

// ==== tb/lss_far_model.sv ====
`timescale 1ns/1ps

module lss_far_model (
    // Clock
    input wire logic   clk,
    // Scanner side
    input wire logic   rx_take,
    input wire logic   dio_valid,
    input wire logic   dio_read,
    input wire logic   [5:0] dio_line,
    // Line modules
    output logic [63:0] rx_ready,
    output logic [7:0]  rx_char,
    output logic [63:0] tx_done
);
    logic [13:0] pend[$];
    logic [5:0]  cur;
    logic [7:0]  c;
    logic        up;
    int          taken;

    initial
    begin
        rx_ready = '0;
        rx_char  = '0;
        tx_done  = '0;
        up       = 1'b0;
        taken    = 0;
    end

    // Raise one waiting receiver at a time, drop it once taken
    always @(posedge clk)
    begin
        if (!up)
            rx_char <= ~rx_char; // Released data toggles
        if (rx_take && up)
        begin
            rx_ready[cur] <= 1'b0;
            up            <= 1'b0;
            taken         <= taken + 1;
        end
        else if (!up && pend.size() != 0)
        begin
            {cur, c} = pend.pop_front();
            rx_ready[cur] <= 1'b1;
            rx_char       <= c;
            up            <= 1'b1;
        end
    end

    // A written send module stops asking for service
    always @(posedge clk)
        if (dio_valid && !dio_read)
            tx_done[dio_line] <= 1'b0;

    task post_rx(input logic [5:0] l, input logic [7:0] ch);
        pend.push_back({l, ch});
    endtask

    task post_tx(input logic [5:0] l);
        tx_done[l] <= 1'b1;
    endtask
endmodule

// ==== tb/lss_scanner_tb.sv ====
`timescale 1ns/1ps
`include "lss_regs.svh"

module lss_scanner_tb;
    logic        clk = 1'b0, reset_n = 1'b0, stall = 1'b1;
    logic        hs_option = 1'b0, hs_tick = 1'b0, ls_tick = 1'b0, mip_ready = 1'b0;
    logic        dio_valid = 1'b0, dio_read = 1'b0, io_op_valid = 1'b0;
    logic [3:0]  dio_func = 4'h0;
    logic [2:0]  io_op = 3'h0;
    logic [5:0]  dio_line = 6'h00;
    logic [7:0]  addr_switch = 8'h5a, dev_num = 8'h00;
    logic [63:0] rx_ready, tx_done;
    logic [7:0]  rx_char, mip_char, rx_grp_sel, tx_grp_sel, fmt3_tick;
    logic [5:0]  rx_line, tx_line, mip_line, dio_rdata;
    logic [2:0]  tx_mod_addr;
    logic        rx_take, mip_valid, dio_rvalid, send_irq, io_selected;
    logic [13:0] exp_q[$];
    integer      seed = 32'h8948;
    int          checks = 0, n_fail = 0, cyc = 0, i;
    logic [5:0]  rxl[6] = '{6'h01, 6'h0c, 6'h3f, 6'h00, 6'h28, 6'h07};
    logic [5:0]  rx_t[3] = '{6'h28, 6'h28, 6'h03}, nx_t[3] = '{6'h29, 6'h3f, 6'h04};
    logic [5:0]  tx_l[4] = '{6'h32, 6'h32, 6'h02, 6'h3f}, tx_n[4] = '{6'h33, 6'h3f, 6'h03, 6'h00};
    logic [3:0]  tx_f[4] = '{4'h9, 4'ha, 4'hb, 4'h9};
    logic        opt[4] = '{1'b0, 1'b1, 1'b1, 1'b0};

    lss_scanner uut (
        .clk(clk), .reset_n(reset_n), .rx_ready(rx_ready), .rx_char(rx_char), .rx_line(rx_line),
        .rx_grp_sel(rx_grp_sel), .rx_take(rx_take), .tx_done(tx_done), .tx_line(tx_line),
        .tx_mod_addr(tx_mod_addr), .tx_grp_sel(tx_grp_sel), .hs_option(hs_option), .hs_tick(hs_tick),
        .ls_tick(ls_tick), .fmt3_tick(fmt3_tick), .mip_valid(mip_valid), .mip_char(mip_char),
        .mip_line(mip_line), .mip_ready(mip_ready), .dio_valid(dio_valid), .dio_read(dio_read),
        .dio_func(dio_func), .dio_line(dio_line), .dio_rdata(dio_rdata), .dio_rvalid(dio_rvalid),
        .send_irq(send_irq), .addr_switch(addr_switch), .dev_num(dev_num), .io_op_valid(io_op_valid),
        .io_op(io_op), .io_selected(io_selected)
    );

    lss_far_model far (
        .clk(clk), .rx_take(rx_take), .dio_valid(dio_valid), .dio_read(dio_read), .dio_line(dio_line),
        .rx_ready(rx_ready), .rx_char(rx_char), .tx_done(tx_done)
    );

    always #2.5 clk = ~clk;

    // Processor accepts at random unless stalled; words checked in order
    always @(posedge clk)
    begin
        mip_ready <= !stall && ($random(seed) % 2 != 0);
        if (reset_n && mip_valid && mip_ready)
            chk({mip_line, mip_char}, exp_q.size() != 0 ? exp_q.pop_front() : 32'hffff);
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            print_verdict();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task print_verdict;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task post(input logic [5:0] l);
        logic [7:0] ch;
        ch = 8'($random(seed));
        exp_q.push_back({l, ch});
        far.post_rx(l, ch);
    endtask

    task direct_host_port(input logic r, input logic [3:0] f, input logic [5:0] l);
        @(posedge clk);
        dio_valid <= 1'b1;
        dio_read  <= r;
        dio_func  <= f;
        dio_line  <= l;
        @(posedge clk);
        dio_valid <= 1'b0;
        dio_line  <= ~l;
        #1;
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        // Fill the buffer while the processor stalls, then drain it
        for (i = 0; i < 6; i++)
            post(rxl[i]);
        wait (far.taken == 4);
        repeat (100) @(posedge clk);
        chk(far.taken, 4);
        stall <= 1'b0;
        wait (exp_q.size() == 0);
        #1;
        chk(far.taken, 6);
        // Next receive line after a delivery, option off and on
        for (i = 0; i < 3; i++)
        begin
            @(posedge clk);
            hs_option <= (i != 0);
            repeat (4) @(posedge clk);
            post(rx_t[i]);
            wait (rx_take && rx_line == rx_t[i]);
            wait (rx_line != rx_t[i]);
            #1;
            chk(rx_line, nx_t[i]);
        end
        // Send service: response read, then releasing write
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            hs_option <= opt[i];
            direct_host_port(1'b1, 4'h1, 6'h00);
            chk({dio_rvalid, dio_rdata}, 7'h40);
            far.post_tx(tx_l[i]);
            wait (send_irq);
            direct_host_port(1'b1, `LSS_FN_OUT_RESP, 6'h00);
            chk({dio_rvalid, dio_rdata}, {1'b1, tx_l[i]});
            direct_host_port(1'b0, tx_f[i], tx_l[i]);
            chk({send_irq, tx_line}, {1'b0, tx_n[i]});
        end
        // Format III timing routing
        for (i = 0; i < 4; i++)
        begin
            @(posedge clk);
            hs_option <= i[1];
            hs_tick   <= i[0];
            ls_tick   <= !i[0];
            repeat (6) @(posedge clk);
            #1;
            chk(fmt3_tick, i[1] ? {{7{!i[0]}}, i[0]} : {8{!i[0]}});
        end
        // Channel operations compare the address switches
        for (i = 0; i < 16; i++)
        begin
            @(posedge clk);
            dev_num     <= i[0] ? 8'h5a : 8'h5b;
            io_op       <= 3'(i >> 1);
            io_op_valid <= 1'b1;
            @(posedge clk);
            io_op_valid <= 1'b0;
            #1;
            chk(io_selected, i[0] && (i >> 1) >= 1 && (i >> 1) <= 4);
        end
        // Second reset returns both scanners to the first line
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({rx_line, tx_line, send_irq, mip_valid}, 14'h0);
        print_verdict();
    end
endmodule
